// ==== hdl/prtr_pkg.sv ====
// Package for the pulse ratio temperature reader.
// Assumes one 40 MHz clock domain.
package prtr_pkg;
  // Counter width for each phase
  localparam int PRTR_CNT_W = 16;
  // Prescale: count once per this many clocks (40 MHz / 40 = 1 MHz)
  localparam int PRTR_CLK_MHZ = 40;
  localparam int PRTR_RES_US = 1;
  localparam int PRTR_DIV = PRTR_CLK_MHZ * PRTR_RES_US;
  localparam int PRTR_DIV_W = 6;
  localparam logic [PRTR_DIV_W-1:0] PRTR_DIV_LAST = 6'(PRTR_DIV - 1);
  localparam logic [PRTR_DIV_W-1:0] PRTR_DIV_ZERO = 6'h00;
  // Counter values
  localparam logic [PRTR_CNT_W-1:0] PRTR_CNT_ZERO = 16'h0000;
  localparam logic [PRTR_CNT_W-1:0] PRTR_CNT_ONE = 16'h0001;
  localparam logic [PRTR_CNT_W-1:0] PRTR_CNT_MAX = 16'hFFFF;
  // Conversion constants used by software downstream
  localparam int PRTR_OFFSET_C = 235;
  localparam int PRTR_SLOPE_C = 400;
  // Capture sequence states, one-hot
  typedef enum logic [4:0] {
    PRTR_IDLE = 5'h01,
    PRTR_WAIT_LO = 5'h02,
    PRTR_WAIT_HI = 5'h04,
    PRTR_HIGH = 5'h08,
    PRTR_LOW = 5'h10
  } prtr_state_t;
endpackage

// ==== hdl/prtr_reader.sv ====
// Capture logic for a duty-cycle encoded temperature sensor line.
// Assumes sense_in is the raw sensor pin; one 40 MHz clock, sync reset.
//
// Contract
// - Measure both high and low phase durations
// - Counting clock stable, fast enough
// - Exact counting frequency need not be precise
// - Clear both counters before watching input
// - Each phase counter is full 16 bits
// - Wait low, then rise starts high count
// - Fall stops high, starts low together
// - Next rise stops low, results kept
// - Counters tick at one microsecond resolution
// - Keep edge-to-count latency minimal
// - Single sensor input line only
// - Temp is 235 minus 400 times ratio
`timescale 1ns/100ps
module prtr_reader (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sense_in,
  input wire logic start,
  output logic busy,
  output logic done,
  output logic overflow,
  output logic [prtr_pkg::PRTR_CNT_W-1:0] high_phase_time,
  output logic [prtr_pkg::PRTR_CNT_W-1:0] low_phase_time
);
  import prtr_pkg::*;

  prtr_state_t state_q;
  prtr_state_t state_d;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [PRTR_DIV_W-1:0] div_q;
  logic [PRTR_CNT_W-1:0] hi_cnt_q;
  logic [PRTR_CNT_W-1:0] lo_cnt_q;
  logic done_q;
  logic ovf_q;

  // Edge and tick decode on the synchronised line
  wire rise = sync2_q & ~prev_q;
  wire fall = ~sync2_q & prev_q;
  wire tick = (div_q == PRTR_DIV_LAST);
  wire in_high = (state_q == PRTR_HIGH);
  wire in_low = (state_q == PRTR_LOW);
  wire hi_full = (hi_cnt_q == PRTR_CNT_MAX);
  wire lo_full = (lo_cnt_q == PRTR_CNT_MAX);

  // Two-flop synchroniser; first stage only feeds the second
  // Reset to the idle-high line level so no false rise follows reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (clk_en) begin
      sync1_q <= sense_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Sequence decode
  always_comb begin
    state_d = state_q;
    case (state_q)
      PRTR_IDLE: begin
        if (start) begin
          state_d = PRTR_WAIT_LO;
        end
      end
      PRTR_WAIT_LO: begin
        if (!sync2_q) begin
          state_d = PRTR_WAIT_HI;
        end
      end
      PRTR_WAIT_HI: begin
        if (rise) begin
          state_d = PRTR_HIGH;
        end
      end
      PRTR_HIGH: begin
        if (fall) begin
          state_d = PRTR_LOW;
        end
      end
      PRTR_LOW: begin
        if (rise) begin
          state_d = PRTR_IDLE;
        end
      end
      default: begin
        state_d = PRTR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PRTR_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Prescaler restarts on each counted edge so phases align to edges
  // One clock times both phases, so its exact rate cancels
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= PRTR_DIV_ZERO;
    end else if (clk_en) begin
      if ((state_q == PRTR_WAIT_HI && rise) || (in_high && fall) || tick) begin
        div_q <= PRTR_DIV_ZERO;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // High phase counter, saturating at full scale
  always_ff @(posedge clk) begin
    if (reset) begin
      hi_cnt_q <= PRTR_CNT_ZERO;
    end else if (clk_en) begin
      if (state_q == PRTR_IDLE && start) begin
        hi_cnt_q <= PRTR_CNT_ZERO;
      end else if (in_high && !fall && tick && !hi_full) begin
        hi_cnt_q <= hi_cnt_q + PRTR_CNT_ONE;
      end
    end
  end

  // Low phase counter, starts in the step the high counter stops
  always_ff @(posedge clk) begin
    if (reset) begin
      lo_cnt_q <= PRTR_CNT_ZERO;
    end else if (clk_en) begin
      if (state_q == PRTR_IDLE && start) begin
        lo_cnt_q <= PRTR_CNT_ZERO;
      end else if (in_low && !rise && tick && !lo_full) begin
        lo_cnt_q <= lo_cnt_q + PRTR_CNT_ONE;
      end
    end
  end

  // Completion and overflow flags
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == PRTR_IDLE && start) begin
        done_q <= 1'b0;
        ovf_q <= 1'b0;
      end else if (in_low && rise) begin
        done_q <= 1'b1;
        ovf_q <= hi_full | lo_full;
      end
    end
  end

  // Outputs; counts hold after completion for the ratio calculation
  assign busy = (state_q != PRTR_IDLE);
  assign done = done_q;
  assign overflow = ovf_q;
  assign high_phase_time = hi_cnt_q;
  assign low_phase_time = lo_cnt_q;

  // Checks
  sequence prtr_fall_s;
    in_high && fall && clk_en;
  endsequence

  sequence prtr_enter_low_s;
    ##1 in_low;
  endsequence

  property prtr_fall_p;
    @(posedge clk) disable iff (reset) prtr_fall_s |-> prtr_enter_low_s;
  endproperty

  high_to_low_a: assert property (prtr_fall_p)
    else $error("fall did not move to low phase");

  clear_on_start_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_IDLE && start && clk_en) |=>
    (hi_cnt_q == PRTR_CNT_ZERO && lo_cnt_q == PRTR_CNT_ZERO && state_q == PRTR_WAIT_LO))
    else $error("counters not cleared at start");

  high_only_a: assert property (@(posedge clk) disable iff (reset)
    (hi_cnt_q != $past(hi_cnt_q)) && !$past(state_q == PRTR_IDLE) |->
    $past(in_high) && hi_cnt_q == $past(hi_cnt_q) + PRTR_CNT_ONE)
    else $error("high counter moved outside high phase");

  low_only_a: assert property (@(posedge clk) disable iff (reset)
    (lo_cnt_q != $past(lo_cnt_q)) && !$past(state_q == PRTR_IDLE) |->
    $past(in_low) && lo_cnt_q == $past(lo_cnt_q) + PRTR_CNT_ONE)
    else $error("low counter moved outside low phase");

  rise_starts_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_WAIT_HI && rise && clk_en) |=> in_high && div_q == PRTR_DIV_ZERO)
    else $error("rise did not start high count");

  done_hold_a: assert property (@(posedge clk) disable iff (reset)
    (in_low && rise && clk_en) |=> done && state_q == PRTR_IDLE
    ##1 (high_phase_time == $past(high_phase_time) || $past(start && clk_en)))
    else $error("results not kept after completion");

  wait_low_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_WAIT_LO && sync2_q && clk_en) |=> state_q == PRTR_WAIT_LO)
    else $error("left wait-low while input high");

  tick_rate_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick) |=> div_q == PRTR_DIV_ZERO)
    else $error("prescaler did not wrap");

  sat_hold_a: assert property (@(posedge clk) disable iff (reset)
    hi_full && !(state_q == PRTR_IDLE && start) |=> hi_full)
    else $error("high counter wrapped");

  sync_path_a: assert property (@(posedge clk) disable iff (reset)
    clk_en ##1 clk_en |=> sync2_q == $past(sense_in, 2))
    else $error("synchroniser delay wrong");

  // Wait-low step followed by the wait-rise step
  sequence prtr_low_seen_s;
    state_q == PRTR_WAIT_LO && !sync2_q && clk_en;
  endsequence

  sequence prtr_wait_rise_s;
    ##1 state_q == PRTR_WAIT_HI;
  endsequence

  property prtr_low_seen_p;
    @(posedge clk) disable iff (reset) prtr_low_seen_s |-> prtr_wait_rise_s;
  endproperty

  low_seen_a: assert property (prtr_low_seen_p)
    else $error("low input did not arm rise wait");

  // Rise wait holds until a rise is seen
  hold_wait_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_WAIT_HI && !rise && clk_en) |=> state_q == PRTR_WAIT_HI)
    else $error("left rise wait without a rise");

  // Reset leaves the reader idle with cleared results
  reset_clear_a: assert property (@(posedge clk)
    reset |=> !busy && !done && !overflow && high_phase_time == PRTR_CNT_ZERO
    && low_phase_time == PRTR_CNT_ZERO)
    else $error("reset did not clear reader");

  // Low clock enable freezes every state element
  freeze_hold_a: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(state_q) && $stable(div_q) && $stable(hi_cnt_q)
    && $stable(lo_cnt_q) && $stable(done_q))
    else $error("state moved while clock enable low");

  // Fall restarts the prescaler with a fresh low count
  low_start_a: assert property (@(posedge clk) disable iff (reset)
    (in_high && fall && clk_en) |=> in_low && div_q == PRTR_DIV_ZERO
    && lo_cnt_q == PRTR_CNT_ZERO)
    else $error("fall did not start low count");

  // High count is frozen once the low phase runs
  high_stop_a: assert property (@(posedge clk) disable iff (reset)
    in_low |=> $stable(hi_cnt_q))
    else $error("high count moved in low phase");

  // Idle reader keeps both results until the next start
  results_kept_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_IDLE && !(start && clk_en)) |=> $stable(hi_cnt_q) && $stable(lo_cnt_q))
    else $error("results changed while idle");

  // Overflow reports a saturated count at completion
  ovf_flag_a: assert property (@(posedge clk) disable iff (reset)
    (in_low && rise && clk_en) |=> overflow == $past(hi_full || lo_full))
    else $error("overflow flag wrong at completion");

  // Taken start clears flags and raises busy
  start_take_a: assert property (@(posedge clk) disable iff (reset)
    (state_q == PRTR_IDLE && start && clk_en) |=> busy && !done && !overflow)
    else $error("start not taken cleanly");

  // Start while busy is ignored
  start_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (busy && start && clk_en && !(in_low && rise)) |=> busy)
    else $error("start while busy disturbed capture");

  // High count steps by one per tick
  high_step_a: assert property (@(posedge clk) disable iff (reset)
    (in_high && !fall && tick && clk_en && !hi_full) |=>
    hi_cnt_q == $past(hi_cnt_q) + PRTR_CNT_ONE)
    else $error("high count missed a tick");

  // Low count steps by one per tick
  low_step_a: assert property (@(posedge clk) disable iff (reset)
    (in_low && !rise && tick && clk_en && !lo_full) |=>
    lo_cnt_q == $past(lo_cnt_q) + PRTR_CNT_ONE)
    else $error("low count missed a tick");

endmodule

// ==== testbench/prtr_sensor.sv ====
// Behavioural sensor model: one pulse line, high phase then low phase.
// Assumes the bench calls emit with phase times in ns.
`timescale 1ns/100ps
module prtr_sensor (
  output logic line
);
  // Line idles high between pulses
  initial line = 1'b1;
  // Low lead-in, high phase, low phase, then the rise that ends it
  task automatic emit(input int hi_ns, input int lo_ns);
    line = 1'b0;
    #700;
    line = 1'b1;
    #(hi_ns);
    line = 1'b0;
    #(lo_ns);
    line = 1'b1;
  endtask
endmodule

// ==== testbench/pulse_ratio_temp_reader_test.sv ====
// Self-checking bench for the pulse ratio reader.
// Assumes the sensor model drives sense_in; 40 MHz clock.
`timescale 1ns/100ps
module pulse_ratio_temp_reader_test;
  import prtr_pkg::*;
  logic clk, reset, clk_en, start, busy, done, overflow, line;
  logic [PRTR_CNT_W-1:0] high_phase_time, low_phase_time;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Rows: high us, low us, freeze flag, expected high, expected low (N.5 us phases)
  int rows [5][5] = '{'{3, 5, 0, 3, 5}, '{0, 1, 0, 0, 1}, '{1, 0, 0, 1, 0},
    '{12, 30, 0, 12, 30}, '{9, 4, 1, 7, 4}};
  prtr_sensor prtr_sensor_i (.line(line));
  prtr_reader prtr_reader_i (.clk(clk), .reset(reset), .clk_en(clk_en), .sense_in(line),
    .start(start), .busy(busy), .done(done), .overflow(overflow),
    .high_phase_time(high_phase_time), .low_phase_time(low_phase_time));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One measurement; a second start while busy must be ignored
  task automatic measure(input int hi, input int lo, input int frz, input int eh,
    input int el);
    int n;
    n = 0;
    @(negedge clk) start = 1'b1;
    @(negedge clk) start = 1'b0;
    check(busy, 1'b1, "busy");
    @(negedge clk) check(high_phase_time | low_phase_time | done, 16'h0000, "clear");
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    fork
      prtr_sensor_i.emit(hi * 1000 + 500, lo * 1000 + 500);
      if (frz != 0) begin
        @(posedge line);
        #2000;
        @(negedge clk) clk_en = 1'b0;
        repeat (80) @(negedge clk);
        clk_en = 1'b1;
      end
    join_none
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(done, 1'b1, "done");
    check(busy, 1'b0, "idle");
    check(high_phase_time, 16'(eh), "high");
    check(low_phase_time, 16'(el), "low");
    check(overflow, 1'b0, "overflow");
    repeat (30) @(negedge clk);
    check(low_phase_time, 16'(el), "kept");
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    start = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check({busy, done, overflow}, 3'h0, "reset flags");
    check(high_phase_time | low_phase_time, 16'h0000, "reset counts");
    for (int i = 0; i < 5; i++) begin
      measure(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4]);
    end
    // Reset in mid high phase, then a clean measurement
    @(negedge clk) start = 1'b1;
    @(negedge clk) start = 1'b0;
    fork
      prtr_sensor_i.emit(5500, 5500);
    join_none
    @(posedge line);
    repeat (60) @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check({busy, done, overflow}, 3'h0, "mid reset flags");
    check(high_phase_time | low_phase_time, 16'h0000, "mid reset counts");
    wait fork;
    measure(2, 3, 0, 2, 3);
    close_out();
  end
endmodule
